/* File: include/wdt_pkg.sv */
// Types shared by the watchdog modules.
// Assumes wdt_regs.svh holds the register constants; period lengths sit in wdt_counter_core.
package wdt_pkg;

	typedef struct packed {
		logic early_warning_irq_en;
		logic [1:0] refresh_window;
		logic run_at_reset_en;
		logic [2:0] period_select;
		logic count_in_low_power_en;
	} cfg_t;

	typedef struct packed {
		logic warn;
		logic ovf;
		logic werr;
	} evt_t;

	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_RESP = 1'b1
	} wr_state_t;

	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} rd_state_t;

endpackage

/* File: include/wdt_regs.svh */
// Register offsets, field positions, reset values and timing counts of the watchdog.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz system clock.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Register byte addresses
`define WDT_ADDR_REFRESH 8'h00
`define WDT_ADDR_STATUS 8'h04
`define WDT_ADDR_MASK 8'h08
`define WDT_ADDR_COUNT 8'h0c
`define WDT_ADDR_CONFIG 8'hc0

// Refresh register key
`define WDT_REFRESH_KEY 8'hac

// Status bits
`define WDT_ST_WARN 0
`define WDT_ST_OVF 1
`define WDT_ST_WERR 2
`define WDT_ST_RUN 3
`define WDT_ST_OPEN 4

// Configuration byte fields
`define WDT_CFG_IRQ 7
`define WDT_CFG_WIN_HI 6
`define WDT_CFG_WIN_LO 5
`define WDT_CFG_RUN 4
`define WDT_CFG_SEL_HI 3
`define WDT_CFG_SEL_LO 1
`define WDT_CFG_LP 0

// Reset values
`define WDT_STATUS_RST 3'h0
`define WDT_MASK_RST 3'h0
`define WDT_CFG_RST 8'h00

// AXI responses
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

// Timing: system clock period and highest low-speed oscillator rate
`define WDT_CLK_PERIOD_NS 4
`define WDT_OSC_MAX_HZ 37683
// Shortest oscillator period in system cycles, rounded up
`define WDT_OSC_DIV_CYCLES ((1000000000 + `WDT_CLK_PERIOD_NS * `WDT_OSC_MAX_HZ - 1) / (`WDT_CLK_PERIOD_NS * `WDT_OSC_MAX_HZ))

`endif

/* File: logic/osc_tick_divider.sv */
// Divider that turns the system clock into low-speed oscillator ticks.
// Assumes one system clock; ticks are one-cycle enables.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.svh"

module osc_tick_divider #(
	parameter int unsigned DIV = `WDT_OSC_DIV_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic run,
	input wire logic restart,
	// Ticks
	output logic tick,
	output logic half_tick
);
	localparam logic [12:0] LAST = 13'(DIV - 1);
	localparam logic [12:0] HALF = 13'(DIV / 2);

	logic [12:0] cnt_q;
	logic [12:0] cnt_d;

	// Phase holds while paused so a halt does not shorten the period
	always_comb begin
		cnt_d = cnt_q;
		if (restart) begin
			cnt_d = 13'h0000;
		end else if (run) begin
			cnt_d = (cnt_q == LAST) ? 13'h0000 : cnt_q + 13'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 13'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = run && !restart && (cnt_q == LAST);
	assign half_tick = run && !restart && (cnt_q == HALF);
endmodule
`default_nettype wire

/* File: logic/wdt_counter_core.sv */
// Watchdog counter, window check, overflow and early-warning detection.
// Assumes ticks from osc_tick_divider and a refresh pulse from the bus.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_counter_core
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration
	input wire cfg_t cfg,
	input wire logic cfg_loaded,
	input wire logic low_power_state,
	// Oscillator ticks
	input wire logic tick,
	input wire logic half_tick,
	// Refresh request
	input wire logic refresh,
	// Divider control
	output logic advance,
	output logic restart,
	// State and events
	output logic running,
	output logic window_open,
	output logic [16:0] count,
	output evt_t evt
);
	logic [16:0] count_q;
	logic [16:0] count_d;
	logic [16:0] last;
	logic [16:0] warn_pt;

	always_comb begin
		case (cfg.period_select)
			3'h0: last = 17'h0007f;
			3'h1: last = 17'h000ff;
			3'h2: last = 17'h001ff;
			3'h3: last = 17'h003ff;
			3'h4: last = 17'h00fff;
			3'h5: last = 17'h03fff;
			3'h6: last = 17'h07fff;
			default: last = 17'h1ffff;
		endcase
	end

	// Three quarters of the period
	assign warn_pt = last - (last >> 2);

	assign running = cfg_loaded && cfg.run_at_reset_en;
	assign advance = running && (!low_power_state || cfg.count_in_low_power_en);
	// Prohibited window codes fall back to a fully open window
	assign window_open = (cfg.refresh_window != 2'h1) || (count_q > (last >> 1));
	assign restart = refresh && running && window_open;

	always_comb begin
		count_d = count_q;
		evt = '0;
		if (refresh && running) begin
			if (window_open) begin
				count_d = 17'h00000;
			end else begin
				evt.werr = 1'b1;
			end
		end
		if (!restart && tick) begin
			if (count_q == last) begin
				count_d = 17'h00000;
				evt.ovf = 1'b1;
			end else begin
				count_d = count_q + 17'h00001;
			end
		end
		if (!restart && half_tick && cfg.early_warning_irq_en && (count_q == warn_pt)) begin
			evt.warn = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_q <= 17'h00000;
		end else begin
			count_q <= count_d;
		end
	end

	assign count = count_q;
endmodule
`default_nettype wire

/* File: logic/windowed_watchdog_timer.sv */
// Windowed watchdog top: AXI4-Lite registers, status and interrupt, reset request.
// Assumes the configuration byte is stable at reset release and
// the low-power input is synchronous to aclk.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.svh"

module windowed_watchdog_timer
	import wdt_pkg::*;
#(
	parameter int unsigned OSC_DIV = `WDT_OSC_DIV_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration byte and chip state
	input wire logic [7:0] config_byte_in,
	input wire logic low_power_state,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Interrupt and reset request
	output logic irq,
	output logic wdt_reset_req
);
	cfg_t cfg;
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic cfg_loaded_q;
	logic cfg_loaded_d;

	logic aw_held_q;
	logic aw_held_d;
	logic [7:0] awaddr_q;
	logic [7:0] awaddr_d;
	logic w_held_q;
	logic w_held_d;
	logic [31:0] wdata_q;
	logic [31:0] wdata_d;
	logic [3:0] wstrb_q;
	logic [3:0] wstrb_d;
	wr_state_t wr_state_q;
	wr_state_t wr_state_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	logic do_write;

	rd_state_t rd_state_q;
	rd_state_t rd_state_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;

	logic [2:0] status_q;
	logic [2:0] status_d;
	logic [2:0] mask_q;
	logic [2:0] mask_d;
	logic rst_req_q;
	logic rst_req_d;
	logic refresh;
	logic [2:0] w1c;

	logic tick;
	logic half_tick;
	logic advance;
	logic restart;
	logic running;
	logic window_open;
	logic [16:0] count;
	evt_t evt;

	// Configuration byte is caught once, on the first edge after reset release
	always_comb begin
		cfg_d = cfg_q;
		cfg_loaded_d = 1'b1;
		if (!cfg_loaded_q) begin
			cfg_d = config_byte_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= `WDT_CFG_RST;
			cfg_loaded_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			cfg_loaded_q <= cfg_loaded_d;
		end
	end

	// Field unpacking of the configuration byte
	assign cfg.early_warning_irq_en = cfg_q[`WDT_CFG_IRQ];
	assign cfg.refresh_window = cfg_q[`WDT_CFG_WIN_HI:`WDT_CFG_WIN_LO];
	assign cfg.run_at_reset_en = cfg_q[`WDT_CFG_RUN];
	assign cfg.period_select = cfg_q[`WDT_CFG_SEL_HI:`WDT_CFG_SEL_LO];
	assign cfg.count_in_low_power_en = cfg_q[`WDT_CFG_LP];

	// Oscillator rate kept at its highest, so periods are the shortest
	osc_tick_divider #(
		.DIV(OSC_DIV)
	) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(advance),
		.restart(restart),
		.tick(tick),
		.half_tick(half_tick)
	);

	wdt_counter_core u_core (
		.aclk(aclk),
		.aresetn(aresetn),
		.cfg(cfg),
		.cfg_loaded(cfg_loaded_q),
		.low_power_state(low_power_state),
		.tick(tick),
		.half_tick(half_tick),
		.refresh(refresh),
		.advance(advance),
		.restart(restart),
		.running(running),
		.window_open(window_open),
		.count(count),
		.evt(evt)
	);

	// Write channel: address and data taken in either order, one write at a time
	assign awready = !aw_held_q && (wr_state_q == WR_IDLE);
	assign wready = !w_held_q && (wr_state_q == WR_IDLE);
	assign bvalid = (wr_state_q == WR_RESP);
	assign bresp = bresp_q;
	assign do_write = aw_held_q && w_held_q && (wr_state_q == WR_IDLE);

	always_comb begin
		aw_held_d = aw_held_q;
		awaddr_d = awaddr_q;
		w_held_d = w_held_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		wr_state_d = wr_state_q;
		bresp_d = bresp_q;
		refresh = 1'b0;
		w1c = 3'h0;
		mask_d = mask_q;
		if (awvalid && awready) begin
			aw_held_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_held_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		case (wr_state_q)
			WR_IDLE: begin
				if (do_write) begin
					aw_held_d = 1'b0;
					w_held_d = 1'b0;
					wr_state_d = WR_RESP;
					bresp_d = `WDT_RESP_OKAY;
					case (awaddr_q)
						`WDT_ADDR_REFRESH: begin
							// A wrong key is ignored so stray writes cannot refresh
							refresh = wstrb_q[0] && (wdata_q[7:0] == `WDT_REFRESH_KEY);
						end
						`WDT_ADDR_STATUS: begin
							if (wstrb_q[0]) begin
								w1c = wdata_q[2:0];
							end
						end
						`WDT_ADDR_MASK: begin
							if (wstrb_q[0]) begin
								mask_d = wdata_q[2:0];
							end
						end
						`WDT_ADDR_COUNT: begin
						end
						`WDT_ADDR_CONFIG: begin
						end
						default: begin
							bresp_d = `WDT_RESP_SLVERR;
						end
					endcase
				end
			end
			WR_RESP: begin
				if (bready) begin
					wr_state_d = WR_IDLE;
				end
			end
			default: begin
				wr_state_d = WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			w_held_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			wr_state_q <= WR_IDLE;
			bresp_q <= `WDT_RESP_OKAY;
			mask_q <= `WDT_MASK_RST;
		end else begin
			aw_held_q <= aw_held_d;
			awaddr_q <= awaddr_d;
			w_held_q <= w_held_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			wr_state_q <= wr_state_d;
			bresp_q <= bresp_d;
			mask_q <= mask_d;
		end
	end

	// Read channel: answer one cycle after the address is taken
	assign arready = (rd_state_q == RD_IDLE);
	assign rvalid = (rd_state_q == RD_RESP);
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	always_comb begin
		rd_state_d = rd_state_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rd_state_q)
			RD_IDLE: begin
				if (arvalid) begin
					rd_state_d = RD_RESP;
					rresp_d = `WDT_RESP_OKAY;
					rdata_d = 32'h00000000;
					case (araddr)
						`WDT_ADDR_REFRESH: begin
						end
						`WDT_ADDR_STATUS: begin
							rdata_d[2:0] = status_q;
							rdata_d[`WDT_ST_RUN] = running;
							rdata_d[`WDT_ST_OPEN] = window_open;
						end
						`WDT_ADDR_MASK: begin
							rdata_d[2:0] = mask_q;
						end
						`WDT_ADDR_COUNT: begin
							rdata_d[16:0] = count;
						end
						`WDT_ADDR_CONFIG: begin
							rdata_d[7:0] = cfg_q;
						end
						default: begin
							rresp_d = `WDT_RESP_SLVERR;
						end
					endcase
				end
			end
			RD_RESP: begin
				if (rready) begin
					rd_state_d = RD_IDLE;
				end
			end
			default: begin
				rd_state_d = RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= RD_IDLE;
			rdata_q <= 32'h00000000;
			rresp_q <= `WDT_RESP_OKAY;
		end else begin
			rd_state_q <= rd_state_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Sticky status; a new event beats a clear in the same cycle
	always_comb begin
		status_d = status_q & ~w1c;
		status_d[`WDT_ST_WARN] = status_d[`WDT_ST_WARN] | evt.warn;
		status_d[`WDT_ST_OVF] = status_d[`WDT_ST_OVF] | evt.ovf;
		status_d[`WDT_ST_WERR] = status_d[`WDT_ST_WERR] | evt.werr;
		// Held until the chip reset takes this block down
		rst_req_d = rst_req_q | evt.ovf | evt.werr;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= `WDT_STATUS_RST;
			rst_req_q <= 1'b0;
		end else begin
			status_q <= status_d;
			rst_req_q <= rst_req_d;
		end
	end

	assign irq = |(status_q & mask_q);
	assign wdt_reset_req = rst_req_q;
endmodule
`default_nettype wire

/* File: verification/tb_windowed_watchdog_timer.sv */
// Self-checking bench for the windowed watchdog top.
// Assumes a short oscillator divider; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.svh"

module tb_windowed_watchdog_timer;
	localparam int unsigned DIV = 8;
	typedef struct {
		logic [7:0] cfg;
		logic lp;
		int unsigned ticks;
	} row_t;
	// Codes 5 to 7 left out: too long even with a short divider
	row_t rows [8] = '{'{8'h70, 1'b0, 128}, '{8'h72, 1'b0, 256}, '{8'h74, 1'b0, 512},
		'{8'h76, 1'b0, 1024}, '{8'h78, 1'b0, 4096}, '{8'h60, 1'b0, 0},
		'{8'h70, 1'b1, 0}, '{8'h71, 1'b1, 128}};
	logic aclk, aresetn, low_power_state, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, wdt_reset_req;
	logic [7:0] config_byte_in, awaddr, araddr;
	logic [31:0] wdata, rdata, rd_v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rd_r, wr_b;
	int err_count, n_compared, n;

	windowed_watchdog_timer #(.OSC_DIV(DIV)) uut (.aclk(aclk), .aresetn(aresetn),
		.config_byte_in(config_byte_in), .low_power_state(low_power_state),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq),
		.wdt_reset_req(wdt_reset_req));

	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	// Tests need about 53k cycles; margin kept well under the run budget
	initial begin
		#300000;
		err_count++;
		results();
	end

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// Tolerance covers capture and reporting latency, up to one whole tick late
	task automatic chk_rng(input string s, input int e, input int g);
		n_compared++;
		if (g < e - 2 || g > e + DIV) begin
			err_count++;
			$display("Error %s expected %0d seen %0d", s, e, g);
		end
	endtask
	task results;
		$display("Compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rst(input logic [7:0] c, input logic l);
		@(posedge aclk);
		aresetn <= 0;
		config_byte_in <= c;
		low_power_state <= l;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
	endtask
	// Ready may come late so the hold checks see a stalled answer; only the watchdog ends a wait
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int dly = 0);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= (dly == 0);
		do begin
			@(posedge aclk);
			t++;
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (!bready && t >= dly) bready <= 1;
		end while (!(bvalid === 1'b1 && bready === 1'b1));
		bready <= 0;
		wr_b = bresp;
	endtask
	task automatic rd(input logic [7:0] a, input int dly = 0);
		int t;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= (dly == 0);
		do begin
			@(posedge aclk);
			t++;
			if (arvalid && arready) arvalid <= 0;
			if (!rready && t >= dly) rready <= 1;
		end while (!(rvalid === 1'b1 && rready === 1'b1));
		rready <= 0;
		rd_v = rdata;
		rd_r = rresp;
	endtask
	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		rd(a);
		chk(s, e, rd_v & m);
	endtask

	initial begin
		{aresetn, low_power_state, awvalid, wvalid, bready, arvalid, rready} = '0;
		{config_byte_in, awaddr, araddr, wdata, wstrb} = '0;
		err_count = 0;
		n_compared = 0;
		foreach (rows[i]) begin
			rst(rows[i].cfg, rows[i].lp);
			n = 0;
			while (wdt_reset_req !== 1'b1 && n < 1200 + rows[i].ticks * DIV) begin
				@(posedge aclk);
				n++;
			end
			if (rows[i].ticks == 0)
				chk("no overflow", 0, wdt_reset_req);
			else
				chk_rng("overflow cycles", rows[i].ticks * DIV, n);
			rc("status row", `WDT_ADDR_STATUS, rows[i].ticks ? 32'h2 : 32'h0, 32'h7);
			$display("Test row %0d done", i);
		end
		rst(8'h60, 0);
		rc("status", `WDT_ADDR_STATUS, 0, 32'hf);
		rc("mask", `WDT_ADDR_MASK, 0, 32'hffffffff);
		rc("config", `WDT_ADDR_CONFIG, 8'h60, 32'hff);
		wr(`WDT_ADDR_CONFIG, 32'hff);
		chk("config wr resp", `WDT_RESP_OKAY, wr_b);
		rc("config ro", `WDT_ADDR_CONFIG, 8'h60, 32'hff);
		rd(8'h10);
		chk("unmapped", `WDT_RESP_SLVERR, rd_r);
		wr(8'h10, 32'h0, 3);
		chk("unmapped wr", `WDT_RESP_SLVERR, wr_b);
		rd(`WDT_ADDR_CONFIG, 3);
		chk("config slow", 8'h60, rd_v & 32'hff);
		wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_KEY);
		rc("count idle", `WDT_ADDR_COUNT, 0, 32'h1ffff);
		chk("req idle", 0, wdt_reset_req);
		$display("Test registers done");
		rst(8'h70, 0);
		repeat (40) @(posedge aclk);
		rc("open bit", `WDT_ADDR_STATUS, 32'h18, 32'h18);
		wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_KEY);
		rc("count cleared", `WDT_ADDR_COUNT, 0, 32'h1ffff);
		chk("req open", 0, wdt_reset_req);
		rst(8'h50, 0);
		wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_KEY);
		repeat (2) @(posedge aclk);
		chk("req window 10", 0, wdt_reset_req);
		rst(8'h10, 0);
		wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_KEY);
		repeat (2) @(posedge aclk);
		chk("req window 00", 0, wdt_reset_req);
		$display("Test full window done");
		rst(8'hb0, 0);
		repeat (80 * DIV) @(posedge aclk);
		wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_KEY);
		chk("req late refresh", 0, wdt_reset_req);
		repeat (100 * DIV) @(posedge aclk);
		chk("irq masked", 0, irq);
		rc("warn", `WDT_ADDR_STATUS, 1, 32'h7);
		wr(`WDT_ADDR_MASK, 1);
		repeat (2) @(posedge aclk);
		chk("irq", 1, irq);
		wr(`WDT_ADDR_STATUS, 1);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 0, irq);
		$display("Test early warning done");
		rst(8'hb0, 0);
		wr(`WDT_ADDR_REFRESH, `WDT_REFRESH_KEY);
		repeat (2) @(posedge aclk);
		chk("req early refresh", 1, wdt_reset_req);
		rc("window error", `WDT_ADDR_STATUS, 32'hc, 32'h1f);
		$display("Test closed window done");
		results();
	end
endmodule
`default_nettype wire

/* File: verification/wdt_asserts.sv */
// Checks on the watchdog top ports: bus answers, reset request, interrupt.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_asserts #(
	parameter int unsigned OSC_DIV = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [7:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Interrupt and reset request
	input wire logic irq,
	input wire logic wdt_reset_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	property p_req_clear;
		disable iff (1'b0) !aresetn |=> !wdt_reset_req;
	endproperty
	property p_irq_clear;
		disable iff (1'b0) !aresetn |=> !irq;
	endproperty
	property p_req_sticky;
		wdt_reset_req |=> wdt_reset_req;
	endproperty
	property p_rd_answer;
		s_rd_taken |=> rvalid;
	endproperty
	property p_wr_answer;
		s_wr_taken |-> ##[1:2] bvalid;
	endproperty
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	// Unmapped place must be refused
	property p_unmapped;
		arvalid && arready && araddr == 8'h10 |=> rresp == `WDT_RESP_SLVERR;
	endproperty
	a_req_clear: assert property (p_req_clear) else $error("reset request after reset");
	a_irq_clear: assert property (p_irq_clear) else $error("irq after reset");
	a_req_sticky: assert property (p_req_sticky) else $error("reset request dropped");
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	a_b_hold: assert property (p_b_hold) else $error("write response not held");
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule

bind windowed_watchdog_timer wdt_asserts #(.OSC_DIV(OSC_DIV)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq), .wdt_reset_req(wdt_reset_req)
);
`default_nettype wire
